/* logic/rat_cfg.svh */
/*
 register map, field positions, reset values and timing for the resolver angle tracker.
 assumes a 32-bit classic wishbone slave with byte addresses.
*/
`ifndef RAT_CFG_SVH
`define RAT_CFG_SVH

// register byte addresses
`define RAT_ADR_CTRL 8'h00
`define RAT_ADR_CMD 8'h04
`define RAT_ADR_PERIOD 8'h08
`define RAT_ADR_DUTY 8'h0C
`define RAT_ADR_DELAY 8'h10
`define RAT_ADR_SCALE 8'h14
`define RAT_ADR_BIAS 8'h18
`define RAT_ADR_SIN 8'h1C
`define RAT_ADR_COS 8'h20
`define RAT_ADR_POSITION 8'h24
`define RAT_ADR_SPEED 8'h28
`define RAT_ADR_REVS 8'h2C
`define RAT_ADR_SINCOS_LOC 8'h30
`define RAT_ADR_IRQ_RATE 8'h34
`define RAT_ADR_STATUS 8'h38
`define RAT_ADR_UPDATE_EXT 8'h3C

// control bits
`define RAT_CTRL_PERIODIC 0
`define RAT_CTRL_MASTER 1
// command bits, write one to fire
`define RAT_CMD_UPDATE 0
`define RAT_CMD_COMPUTE 1
`define RAT_CMD_STOP 2
`define RAT_CMD_START 3
// status bits
`define RAT_STAT_RUNNING 0
`define RAT_STAT_PWM 1
`define RAT_STAT_UPD_PEND 2

// reset values
`define RAT_PERIOD_RST 24'h000000
`define RAT_DUTY_RST 24'h000000
`define RAT_DELAY_RST 24'h000000
`define RAT_SCALE_RST 5'h00
`define RAT_BIAS_RST 24'h000000
`define RAT_RATE_RST 16'h0000

// observer geometry
`define RAT_QUARTER_TURN 24'h400000
`define RAT_ONE_Q23 24'h800000
`define RAT_MAX_Q23 24'h7FFFFF

// time base: system clock counts per tick
`define RAT_TICK_DIV 16'h0001
`endif

/* logic/rat_pkg.sv */
/*
 types shared by the resolver angle tracker modules.
 assumes rat_cfg.svh supplies the numeric constants.
*/
package rat_pkg;
   // one set of pwm timing values, all in time base ticks
   typedef struct packed {
      logic [23:0] period;
      logic [23:0] duty;
      logic [23:0] delay;
   } rat_timing_t;

   // observer results
   typedef struct packed {
      logic [23:0] angle;
      logic [23:0] speed;
      logic [31:0] revs;
   } rat_obs_t;
endpackage

/* logic/rat_observer.sv */
/*
 angle tracking observer: one iteration per start pulse, result one cycle later.
 assumes conditioned q23 sine and cosine samples held stable while start is high.
*/
`timescale 1ns/100ps
`include "rat_cfg.svh"

module rat_observer #(
   parameter int K1_SHIFT = 4,
   parameter int K2_SHIFT = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [23:0] sin_in,
   input wire logic [23:0] cos_in,
   output rat_pkg::rat_obs_t obs,
   output logic done
);
   rat_pkg::rat_obs_t obs_q, obs_d;
   logic done_q;

   // parabolic sine of pi*x, cheap and smooth enough to steer the loop
   function automatic logic [23:0] sin_apx(input logic [23:0] x);
      logic [23:0] mag;
      logic [23:0] rest;
      logic signed [48:0] prod;
      logic signed [48:0] r;
      mag = x[23] ? (~x + 24'h000001) : x;
      rest = `RAT_ONE_Q23 - mag;
      prod = $signed({{25{x[23]}}, x}) * $signed({25'h0000000, rest});
      r = prod >>> 21;
      if (r > $signed({25'h0000000, `RAT_MAX_Q23})) begin
         sin_apx = `RAT_MAX_Q23;
      end else if (r < -$signed({25'h0000000, `RAT_MAX_Q23})) begin
         sin_apx = ~`RAT_MAX_Q23 + 24'h000001;
      end else begin
         sin_apx = r[23:0];
      end
   endfunction

   // error = sin(in)cos(est) - cos(in)sin(est), then two integrators
   always_comb begin
      logic [23:0] se;
      logic [23:0] ce;
      logic signed [47:0] e_full;
      logic [23:0] err;
      logic [23:0] spd;
      logic [23:0] ang;
      se = sin_apx(obs_q.angle);
      ce = sin_apx(obs_q.angle + `RAT_QUARTER_TURN);
      e_full = $signed(sin_in) * $signed(ce) - $signed(cos_in) * $signed(se);
      err = e_full[46:23];
      spd = obs_q.speed + 24'($signed(err) >>> K2_SHIFT);
      ang = obs_q.angle + spd + 24'($signed(err) >>> K1_SHIFT);
      obs_d = obs_q;
      if (start) begin
         obs_d.speed = spd;
         obs_d.angle = ang;
         // wrap across +pi/-pi moves the turn count
         if (obs_q.angle[23:22] == 2'b01 && ang[23:22] == 2'b10) begin
            obs_d.revs = obs_q.revs + 32'h00000001;
         end else if (obs_q.angle[23:22] == 2'b10 && ang[23:22] == 2'b01) begin
            obs_d.revs = obs_q.revs - 32'h00000001;
         end
      end
   end

   // state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         obs_q <= '0;
         done_q <= 1'b0;
      end else begin
         obs_q <= obs_d;
         done_q <= start;
      end
   end

   assign obs = obs_q;
   assign done = done_q;
endmodule // rat_observer

/* logic/rat_top.sv */
/*
 resolver angle tracker: left-aligned reference pwm, staged timing, sample
 conditioning, angle tracking observer and readouts behind a wishbone slave.
 assumes a classic wishbone master on SYS_CLK and that software keeps duty and
 delay below period and picks scale and bias that keep samples in range.
*/
`timescale 1ns/100ps
`include "rat_cfg.svh"

module rat_top #(
   parameter logic [15:0] TICK_DIV = `RAT_TICK_DIV,
   parameter int K1_SHIFT = 4,
   parameter int K2_SHIFT = 8
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic PWM_OUT,
   output logic IRQ_REQ
);
   // bus side state
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   // configuration
   logic periodic_q, periodic_d;
   logic master_q, master_d;
   rat_pkg::rat_timing_t stg_q, stg_d;
   rat_pkg::rat_timing_t act_q, act_d;
   logic upd_pend_q, upd_pend_d;
   logic [4:0] scale_q, scale_d;
   logic [23:0] bias_q, bias_d;
   logic [31:0] sin_q, sin_d;
   logic [31:0] cos_q, cos_d;
   logic [23:0] offset_q, offset_d;
   logic [15:0] rate_q, rate_d;
   // pwm engine
   logic [15:0] tdiv_q, tdiv_d;
   logic running_q, running_d;
   logic [23:0] cnt_q, cnt_d;
   logic pwm_q, pwm_d;
   // observer feed and interrupt pacing
   logic go_q, go_d;
   logic [23:0] csin_q, csin_d;
   logic [23:0] ccos_q, ccos_d;
   logic [15:0] irqc_q, irqc_d;
   logic irq_q, irq_d;
   // observer results
   rat_pkg::rat_obs_t obs;
   logic obs_done;

   // byte lane merge for partial writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // conditioning: low 24 bits only, shift by scale, add bias, wrap to q23
   function automatic logic [23:0] cond(input logic [31:0] raw, input logic [4:0] sh,
                                        input logic [23:0] b);
      logic [23:0] v;
      v = raw[23:0] << sh;
      return v + b;
   endfunction

   rat_observer #(
      .K1_SHIFT(K1_SHIFT),
      .K2_SHIFT(K2_SHIFT)
   ) u_obs (
      .clk(SYS_CLK),
      .rst(RST),
      .start(go_q),
      .sin_in(csin_q),
      .cos_in(ccos_q),
      .obs(obs),
      .done(obs_done)
   );

   // next state of bus, configuration, pwm engine and observer feed
   always_comb begin
      logic req;
      logic wr;
      logic [31:0] old;
      logic [31:0] w;
      logic [23:0] pos;
      logic tick;
      logic wrap;
      logic c_upd;
      logic c_cmp;
      logic c_stop;
      logic c_start;
      logic hit;
      req = WB_CYC_I & WB_STB_I & ~ack_q;
      wr = req & WB_WE_I;
      w = 32'h00000000;
      tick = 1'b0;
      wrap = 1'b0;
      hit = 1'b0;
      pos = obs.angle + offset_q;
      c_upd = 1'b0;
      c_cmp = 1'b0;
      c_stop = 1'b0;
      c_start = 1'b0;
      ack_d = req;
      dat_d = dat_q;
      periodic_d = periodic_q;
      master_d = master_q;
      stg_d = stg_q;
      act_d = act_q;
      upd_pend_d = upd_pend_q;
      scale_d = scale_q;
      bias_d = bias_q;
      sin_d = sin_q;
      cos_d = cos_q;
      offset_d = offset_q;
      rate_d = rate_q;
      tdiv_d = tdiv_q;
      running_d = running_q;
      cnt_d = cnt_q;
      irqc_d = irqc_q;
      irq_d = 1'b0;

      // read mux, unmapped offsets read zero
      old = 32'h00000000;
      case (WB_ADR_I)
         `RAT_ADR_CTRL: begin
            old[`RAT_CTRL_PERIODIC] = periodic_q;
            old[`RAT_CTRL_MASTER] = master_q;
         end
         `RAT_ADR_PERIOD: old = {8'h00, stg_q.period};
         `RAT_ADR_DUTY: old = {8'h00, stg_q.duty};
         `RAT_ADR_DELAY: old = {8'h00, stg_q.delay};
         `RAT_ADR_SCALE: old = {27'h0000000, scale_q};
         `RAT_ADR_BIAS: old = {8'h00, bias_q};
         `RAT_ADR_SIN: old = sin_q;
         `RAT_ADR_COS: old = cos_q;
         `RAT_ADR_POSITION: old = {{8{pos[23]}}, pos};
         `RAT_ADR_SPEED: old = {{8{obs.speed[23]}}, obs.speed};
         `RAT_ADR_REVS: old = obs.revs;
         `RAT_ADR_SINCOS_LOC: old = {24'h000000, `RAT_ADR_SIN};
         `RAT_ADR_IRQ_RATE: old = {16'h0000, rate_q};
         `RAT_ADR_STATUS: begin
            old[`RAT_STAT_RUNNING] = running_q;
            old[`RAT_STAT_PWM] = pwm_q;
            old[`RAT_STAT_UPD_PEND] = upd_pend_q;
         end
         `RAT_ADR_UPDATE_EXT: old = {8'h00, stg_q.delay};
         default: old = 32'h00000000;
      endcase
      if (req & ~WB_WE_I) begin
         dat_d = old;
      end
      w = lane_merge(old, WB_DAT_I, WB_SEL_I);

      // register writes; staged timing only, the active set is untouched
      if (wr) begin
         case (WB_ADR_I)
            `RAT_ADR_CTRL: begin
               periodic_d = w[`RAT_CTRL_PERIODIC];
               master_d = w[`RAT_CTRL_MASTER];
            end
            `RAT_ADR_CMD: begin
               c_upd = w[`RAT_CMD_UPDATE] & WB_SEL_I[0];
               c_cmp = w[`RAT_CMD_COMPUTE] & WB_SEL_I[0];
               c_stop = w[`RAT_CMD_STOP] & WB_SEL_I[0];
               c_start = w[`RAT_CMD_START] & WB_SEL_I[0];
            end
            `RAT_ADR_PERIOD: stg_d.period = w[23:0];
            `RAT_ADR_DUTY: stg_d.duty = w[23:0];
            `RAT_ADR_DELAY: stg_d.delay = w[23:0];
            `RAT_ADR_SCALE: scale_d = w[4:0];
            `RAT_ADR_BIAS: bias_d = w[23:0];
            `RAT_ADR_SIN: sin_d = w;
            `RAT_ADR_COS: cos_d = w;
            `RAT_ADR_POSITION: offset_d = w[23:0] - obs.angle;
            `RAT_ADR_IRQ_RATE: rate_d = w[15:0];
            `RAT_ADR_UPDATE_EXT: begin
               stg_d.delay = w[23:0];
               c_upd = 1'b1;
            end
            default: ;
         endcase
      end

      // time base divider
      tick = (tdiv_q >= TICK_DIV - 16'h0001);
      tdiv_d = tick ? 16'h0000 : tdiv_q + 16'h0001;

      // periodic compute point inside the active period
      hit = tick & running_q & periodic_q & (cnt_q == act_q.delay);

      // period counter; staged set moves in only at a period start
      wrap = (act_q.period == 24'h000000) || (cnt_q >= act_q.period - 24'h000001);
      if (running_q & tick) begin
         if (wrap) begin
            cnt_d = 24'h000000;
            if (upd_pend_q) begin
               act_d = stg_q;
               upd_pend_d = 1'b0;
            end
         end else begin
            cnt_d = cnt_q + 24'h000001;
         end
      end
      // start in master mode begins a fresh period with the staged set
      if (c_start & master_d & ~running_q) begin
         running_d = 1'b1;
         cnt_d = 24'h000000;
         act_d = stg_d;
         upd_pend_d = 1'b0;
      end
      // a fresh update wins over the clear of the pending flag
      if (c_upd) begin
         upd_pend_d = 1'b1;
      end
      // stop, or leaving master mode, ends wave and periodic scheduling
      if (c_stop | ~master_d) begin
         running_d = 1'b0;
      end
      pwm_d = running_d & (cnt_d < act_d.duty);

      // one iteration per compute, periodic or not, running or not
      go_d = c_cmp | hit;
      csin_d = go_d ? cond(sin_q, scale_q, bias_q) : csin_q;
      ccos_d = go_d ? cond(cos_q, scale_q, bias_q) : ccos_q;

      // interrupt pacing counts finished iterations
      if (obs_done) begin
         if (irqc_q >= rate_q) begin
            irqc_d = 16'h0000;
            irq_d = 1'b1;
         end else begin
            irqc_d = irqc_q + 16'h0001;
         end
      end
   end

   // registers only
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
         periodic_q <= 1'b0;
         master_q <= 1'b0;
         stg_q <= {`RAT_PERIOD_RST, `RAT_DUTY_RST, `RAT_DELAY_RST};
         act_q <= {`RAT_PERIOD_RST, `RAT_DUTY_RST, `RAT_DELAY_RST};
         upd_pend_q <= 1'b0;
         scale_q <= `RAT_SCALE_RST;
         bias_q <= `RAT_BIAS_RST;
         sin_q <= 32'h00000000;
         cos_q <= 32'h00000000;
         offset_q <= 24'h000000;
         rate_q <= `RAT_RATE_RST;
         tdiv_q <= 16'h0000;
         running_q <= 1'b0;
         cnt_q <= 24'h000000;
         pwm_q <= 1'b0;
         go_q <= 1'b0;
         csin_q <= 24'h000000;
         ccos_q <= 24'h000000;
         irqc_q <= 16'h0000;
         irq_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         periodic_q <= periodic_d;
         master_q <= master_d;
         stg_q <= stg_d;
         act_q <= act_d;
         upd_pend_q <= upd_pend_d;
         scale_q <= scale_d;
         bias_q <= bias_d;
         sin_q <= sin_d;
         cos_q <= cos_d;
         offset_q <= offset_d;
         rate_q <= rate_d;
         tdiv_q <= tdiv_d;
         running_q <= running_d;
         cnt_q <= cnt_d;
         pwm_q <= pwm_d;
         go_q <= go_d;
         csin_q <= csin_d;
         ccos_q <= ccos_d;
         irqc_q <= irqc_d;
         irq_q <= irq_d;
      end
   end

   // outputs straight from flops
   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign PWM_OUT = pwm_q;
   assign IRQ_REQ = irq_q;
endmodule // rat_top

/* testbench/rat_top_sva.sv */
/*
 bus and output checks for the resolver angle tracker top.
 assumes only the top ports are visible; attached by bind below.
*/
`timescale 1ns/100ps
module rat_top_sva (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic PWM_OUT,
   input wire logic IRQ_REQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // a request taken by the slave, and its read and stop variants
   sequence take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence rd_take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I;
   endsequence
   sequence stop_take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h04 && WB_SEL_I[0] && WB_DAT_I[2];
   endsequence
   chk_ack_latency: assert property (take |=> WB_ACK_O) else $error("ack late");
   chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
   chk_loc_value: assert property (rd_take ##0 WB_ADR_I == 8'h30 |=> WB_DAT_O == 32'h0000001C)
      else $error("sample location wrong");
   chk_cmd_reads: assert property (rd_take ##0 WB_ADR_I == 8'h04 |=> WB_DAT_O == 32'h00000000)
      else $error("command reads nonzero");
   chk_unmapped_zero: assert property (rd_take ##0 WB_ADR_I > 8'h3C |=> WB_DAT_O == 32'h00000000)
      else $error("unmapped read nonzero");
   chk_dat_hold: assert property (!(WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I) |=> $stable(WB_DAT_O))
      else $error("read data moved");
   // no iteration can have finished in the first cycles after reset
   chk_irq_after_rst: assert property ($fell(RST) |-> !IRQ_REQ ##1 !IRQ_REQ ##1 !IRQ_REQ)
      else $error("interrupt request right after reset");
   // a start needs another full bus cycle, so three cycles on the wave must be low
   chk_stop_pwm: assert property (stop_take |-> ##3 !PWM_OUT)
      else $error("wave still running after stop");
endmodule // rat_top_sva

bind rat_top rat_top_sva i_rat_top_sva (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .PWM_OUT(PWM_OUT), .IRQ_REQ(IRQ_REQ));

/* testbench/rat_host_bfm.sv */
/*
 classic wishbone master standing in for the host cpu.
 assumes the slave acks; the bench watchdog ends a hang.
*/
`timescale 1ns/100ps
module rat_host_bfm (
   input wire logic clk,
   input wire logic ack,
   input wire logic [31:0] dat_i,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat_o
);
   // idle bus from time zero
   initial begin
      {cyc, stb, we, adr, sel, dat_o} = '0;
   end
   // one single cycle; held until ack is sampled, released at that edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_o <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_i;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
endmodule // rat_host_bfm

/* testbench/rat_top_tb.sv */
/*
 register level tests of the resolver angle tracker.
 assumes the host model drives the bus and TICK_DIV of one.
*/
`timescale 1ns/100ps
`include "rat_cfg.svh"
module rat_top_tb;
   logic SYS_CLK;
   logic RST;
   logic cyc, stb, we, ack, pwm, irq;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   int n_mismatch = 0;
   int compares = 0;
   int n_irq = 0;

   rat_host_bfm i_rat_host_bfm (.clk(SYS_CLK), .ack(ack), .dat_i(rdat), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(sel), .dat_o(wdat));
   rat_top #(.TICK_DIV(16'h0001)) i_rat_top (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .PWM_OUT(pwm), .IRQ_REQ(irq));

   // 125 MHz clock
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   // nonblocking count so tasks see a stable edge value
   always @(posedge SYS_CLK) begin
      if (irq === 1'b1) n_irq <= n_irq + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_rat_host_bfm.xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      i_rat_host_bfm.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // count high cycles and irqs over k periods from a rising edge; no sync when h is zero
   task automatic pw(input int p, input int k, input int h, input int ni);
      int hi;
      int n0;
      hi = 0;
      if (h > 0) begin
         @(posedge SYS_CLK iff pwm === 1'b0);
         @(posedge SYS_CLK iff pwm === 1'b1);
      end
      n0 = n_irq;
      repeat (p * k) begin
         @(posedge SYS_CLK);
         if (pwm === 1'b1) hi++;
      end
      chk(32'(hi), 32'(h * k));
      chk(32'(n_irq - n0), 32'(ni));
   endtask
   task automatic tally_and_finish;
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // main sequence
   initial begin
      RST = 1'b1;
      repeat (3) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd_chk(`RAT_ADR_PERIOD, 32'h00000000);
      wr(`RAT_ADR_PERIOD, 32'hFFFFFFFF);
      rd_chk(`RAT_ADR_PERIOD, 32'h00FFFFFF);
      rd_chk(`RAT_ADR_SINCOS_LOC, 32'h0000001C);
      rd_chk(8'h40, 32'h00000000);
      wr(`RAT_ADR_POSITION, 32'h00800000);
      rd_chk(`RAT_ADR_POSITION, 32'hFF800000);
      wr(`RAT_ADR_POSITION, 32'h00123456);
      rd_chk(`RAT_ADR_POSITION, 32'h00123456);
      // start without master mode must leave the wave off
      wr(`RAT_ADR_CMD, 32'h00000008);
      rd_chk(`RAT_ADR_STATUS, 32'h00000000);
      // master wave, duty and delay kept below period
      wr(`RAT_ADR_CTRL, 32'h00000002);
      wr(`RAT_ADR_PERIOD, 32'h0000000A);
      wr(`RAT_ADR_DUTY, 32'h00000004);
      wr(`RAT_ADR_DELAY, 32'h00000002);
      wr(`RAT_ADR_CMD, 32'h00000008);
      pw(10, 2, 4, 0);
      wr(`RAT_ADR_PERIOD, 32'h00000006);
      wr(`RAT_ADR_DUTY, 32'h00000002);
      pw(10, 1, 4, 0);
      wr(`RAT_ADR_CMD, 32'h00000001);
      pw(6, 2, 2, 0);
      wr(`RAT_ADR_PERIOD, 32'h00000008);
      wr(`RAT_ADR_DUTY, 32'h00000003);
      wr(`RAT_ADR_UPDATE_EXT, 32'h00000001);
      pw(8, 2, 3, 0);
      // periodic iterations, one irq each, then every second
      wr(`RAT_ADR_CTRL, 32'h00000003);
      pw(8, 4, 3, 4);
      wr(`RAT_ADR_IRQ_RATE, 32'h00000001);
      pw(8, 4, 3, 2);
      wr(`RAT_ADR_CMD, 32'h00000004);
      // an iteration started on the stop edge still finishes; let its irq pass
      repeat (4) @(posedge SYS_CLK);
      pw(8, 2, 0, 0);
      rd_chk(`RAT_ADR_STATUS, 32'h00000000);
      wr(`RAT_ADR_IRQ_RATE, 32'h00000000);
      wr(`RAT_ADR_CMD, 32'h00000002);
      pw(8, 1, 0, 1);
      wr(`RAT_ADR_CMD, 32'h00000002);
      pw(8, 1, 0, 1);
      wr(`RAT_ADR_POSITION, 32'h007FFFFF);
      rd_chk(`RAT_ADR_POSITION, 32'h007FFFFF);
      // one iteration at angle zero: conditioned sine 100000, cosine 20
      wr(`RAT_ADR_SCALE, 32'h00000001);
      wr(`RAT_ADR_BIAS, 32'h00000020);
      wr(`RAT_ADR_SIN, 32'hAB07FFF0);
      wr(`RAT_ADR_COS, 32'h5A000000);
      wr(`RAT_ADR_CMD, 32'h00000002);
      rd_chk(`RAT_ADR_SPEED, 32'h00000FFF);
      rd_chk(`RAT_ADR_POSITION, 32'hFF810FFD);
      rd_chk(`RAT_ADR_REVS, 32'h00000000);
      tally_and_finish;
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      n_mismatch++;
      tally_and_finish;
   end
endmodule // rat_top_tb
